// file: hdl/bridge_window_pkg.sv
/*
  Constants for the bridge window and control register block: offsets,
  field positions, reset values and address decode constants.
  Assumes a word-aligned byte address on the register port.
*/
// What this block does
// - prefetch bottom bits 63:32 are a cleared read/write register used by memory decode
// - prefetch top bits 63:32 are a cleared read/write register used by memory decode
// - I/O bottom bits 31:16 are a cleared read/write field used by I/O decode
// - I/O top bits 31:16 are a cleared read/write field used by I/O decode
// - capability pointer reads fixed 80h
// - interrupt routing byte is plain storage; firmware writes FFh there
// - interrupt pin byte at bits 15:8 reads zero
// - bridge control bit 16 enables secondary parity error detection and reporting
// - bridge control bit 17 forwards secondary system error to the primary
// - with bit 18 clear every in-window I/O address from the primary is forwarded downstream
// - with alias blocking, in-window low 64KB aliases are not forwarded downstream
// - with alias blocking, secondary aliases in the last 768 bytes go upstream
// - alias blocking touches only in-window addresses within the lowest 64KB
// - prefetch bottom bits 19:0 read as zero
// - prefetch top bits 19:0 read as all ones
package bridge_window_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_PF_BOTTOM_HI = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_PF_TOP_HI = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_IO_HI = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_CAP_PTR = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_INTR_CTRL = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_EVENT_MASK = 8'h44;

  localparam int IO_TOP_LSB = 16;
  localparam int INTR_PIN_LSB = 8;
  localparam int CTRL_PARITY_BIT = 16;
  localparam int CTRL_SERR_FWD_BIT = 17;
  localparam int CTRL_ISA_BIT = 18;

  localparam logic [7:0] CAP_PTR_VALUE = 8'h80;
  localparam logic [7:0] INTR_PIN_VALUE = 8'h00;
  localparam logic [7:0] INTR_ROUTE_RESET = 8'h00;
  localparam logic [31:0] HI_RESET = 32'h0000_0000;
  localparam logic [15:0] IO_HI_RESET = 16'h0000;

  localparam logic [19:0] PF_LOW_BOTTOM = 20'h0_0000;
  localparam logic [19:0] PF_LOW_TOP = 20'hF_FFFF;
  localparam logic [11:0] IO_LOW_BOTTOM = 12'h000;
  localparam logic [11:0] IO_LOW_TOP = 12'hFFF;

  // alias: below 64KB and offset 100h..3FFh within a 1KB block
  localparam logic [15:0] IO_BELOW_64K_HI = 16'h0000;
  localparam logic [1:0] ISA_SAFE_QUARTER = 2'h0;

  localparam int EV_W = 3;
  localparam int EV_PARITY = 0;
  localparam int EV_SERR = 1;
  localparam int EV_ALIAS = 2;
  localparam logic [EV_W-1:0] EV_RESET = 3'h0;
endpackage

// file: hdl/window_match.sv
/*
  Range compare of one address against an inclusive bottom/top pair.
  Assumes both bounds are already assembled to full width.
*/
`timescale 1ns/100ps
module window_match #(
  parameter int W = 32
) (
  input wire logic [W-1:0] addr_i,
  input wire logic [W-1:0] bottom_i,
  input wire logic [W-1:0] top_i,
  output logic hit_o
);
  always_comb begin
    hit_o = (addr_i >= bottom_i) && (addr_i <= top_i);
  end
endmodule

// file: hdl/pin_sync3.sv
/*
  Three-stage pin synchroniser; the output moves only once the second
  and third stages agree. Assumes an asynchronous, free-changing pin.
*/
`timescale 1ns/100ps
module pin_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic pin_i,
  output logic level_o
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic level_q;
  logic level_d;

  always_comb begin
    sh_d = sh_q;
    level_d = level_q;
    if (clk_en_i) begin
      sh_d = {sh_q[1:0], pin_i};
      // first stage is read only by the second
      if (sh_q[1] == sh_q[2]) begin
        level_d = sh_q[2];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_q <= {3{RESET_VAL}};
      level_q <= RESET_VAL;
    end else begin
      sh_q <= sh_d;
      level_q <= level_d;
    end
  end

  assign level_o = level_q;
endmodule

// file: hdl/bridge_window_regs.sv
/*
  Upper window registers, capability pointer, interrupt bytes and the
  low bridge control bits, with memory and I/O forward decisions.
  Assumes a single-cycle register port and lower window fields supplied
  by the neighbouring header logic on the same clock.
*/
`timescale 1ns/100ps
module bridge_window_regs
  import bridge_window_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [bridge_window_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [11:0] pf_bottom_low_i,
  input wire logic [11:0] pf_top_low_i,
  input wire logic [3:0] io_bottom_low_i,
  input wire logic [3:0] io_top_low_i,
  input wire logic mem_check_i,
  input wire logic [63:0] mem_addr_i,
  output logic mem_valid_o,
  output logic mem_fwd_o,
  input wire logic io_check_i,
  input wire logic io_from_secondary_i,
  input wire logic [31:0] io_addr_i,
  output logic io_valid_o,
  output logic io_fwd_o,
  input wire logic sec_parity_err_i,
  input wire logic secondary_system_error_in_n_i,
  output logic pri_serr_fwd_o,
  output logic irq_o
);
  import bridge_window_pkg::*;

  logic [31:0] pf_bottom_hi_q;
  logic [31:0] pf_bottom_hi_d;
  logic [31:0] pf_top_hi_q;
  logic [31:0] pf_top_hi_d;
  logic [15:0] io_bottom_hi_q;
  logic [15:0] io_bottom_hi_d;
  logic [15:0] io_top_hi_q;
  logic [15:0] io_top_hi_d;
  logic [7:0] intr_route_q;
  logic [7:0] intr_route_d;
  logic parity_en_q;
  logic parity_en_d;
  logic serr_fwd_en_q;
  logic serr_fwd_en_d;
  logic isa_en_q;
  logic isa_en_d;
  logic [EV_W-1:0] ev_status_q;
  logic [EV_W-1:0] ev_status_d;
  logic [EV_W-1:0] ev_mask_q;
  logic [EV_W-1:0] ev_mask_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irq_q;
  logic irq_d;

  logic mem_valid_q;
  logic mem_valid_d;
  logic mem_fwd_q;
  logic mem_fwd_d;
  logic io_valid_q;
  logic io_valid_d;
  logic io_fwd_q;
  logic io_fwd_d;
  logic serr_out_q;
  logic serr_out_d;

  logic parity_lvl;
  logic parity_lvl_q;
  logic serr_n_lvl;
  logic serr_n_lvl_q;
  logic parity_rise;
  logic serr_fall;

  logic [63:0] pf_bottom;
  logic [63:0] pf_top;
  logic [31:0] io_bottom;
  logic [31:0] io_top;
  logic mem_hit;
  logic io_hit;
  logic io_low64k;
  logic io_alias;
  logic io_block;
  logic [EV_W-1:0] ev_set;
  logic [31:0] rd_mux;

  // assembled windows: low prefetch bits fixed, low I/O bits fixed
  always_comb begin
    pf_bottom = {pf_bottom_hi_q, pf_bottom_low_i, PF_LOW_BOTTOM};
    pf_top = {pf_top_hi_q, pf_top_low_i, PF_LOW_TOP};
    io_bottom = {io_bottom_hi_q, io_bottom_low_i, IO_LOW_BOTTOM};
    io_top = {io_top_hi_q, io_top_low_i, IO_LOW_TOP};
  end

  window_match #(
    .W(64)
  ) u_mem_match (
    .addr_i(mem_addr_i),
    .bottom_i(pf_bottom),
    .top_i(pf_top),
    .hit_o(mem_hit)
  );

  window_match #(
    .W(32)
  ) u_io_match (
    .addr_i(io_addr_i),
    .bottom_i(io_bottom),
    .top_i(io_top),
    .hit_o(io_hit)
  );

  pin_sync3 #(
    .RESET_VAL(1'b0)
  ) u_parity_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .pin_i(sec_parity_err_i),
    .level_o(parity_lvl)
  );

  pin_sync3 #(
    .RESET_VAL(1'b1)
  ) u_serr_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .pin_i(secondary_system_error_in_n_i),
    .level_o(serr_n_lvl)
  );

  // alias decode
  always_comb begin
    io_low64k = (io_addr_i[31:16] == IO_BELOW_64K_HI);
    io_alias = (io_addr_i[9:8] != ISA_SAFE_QUARTER);
    io_block = isa_en_q && io_hit && io_low64k && io_alias;
  end

  // forwarding decisions, one cycle after the check strobe
  always_comb begin
    mem_valid_d = mem_valid_q;
    mem_fwd_d = mem_fwd_q;
    io_valid_d = io_valid_q;
    io_fwd_d = io_fwd_q;
    if (clk_en_i) begin
      mem_valid_d = mem_check_i;
      io_valid_d = io_check_i;
      if (mem_check_i) begin
        mem_fwd_d = mem_hit;
      end
      if (io_check_i) begin
        if (io_from_secondary_i) begin
          // upstream: outside window, or a blocked alias left on the secondary
          io_fwd_d = !io_hit || io_block;
        end else begin
          io_fwd_d = io_hit && !io_block;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_valid_q <= 1'b0;
      mem_fwd_q <= 1'b0;
      io_valid_q <= 1'b0;
      io_fwd_q <= 1'b0;
    end else begin
      mem_valid_q <= mem_valid_d;
      mem_fwd_q <= mem_fwd_d;
      io_valid_q <= io_valid_d;
      io_fwd_q <= io_fwd_d;
    end
  end

  // events from the secondary pins and the downstream alias block
  always_comb begin
    parity_rise = parity_lvl && !parity_lvl_q;
    serr_fall = !serr_n_lvl && serr_n_lvl_q;
    ev_set = '0;
    ev_set[EV_PARITY] = parity_rise && parity_en_q;
    ev_set[EV_SERR] = serr_fall;
    ev_set[EV_ALIAS] = io_check_i && !io_from_secondary_i && io_block;
  end

  // system error forward is a level while the synced input is low
  always_comb begin
    serr_out_d = serr_out_q;
    if (clk_en_i) begin
      serr_out_d = serr_fwd_en_q && !serr_n_lvl;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      parity_lvl_q <= 1'b0;
      serr_n_lvl_q <= 1'b1;
      serr_out_q <= 1'b0;
    end else begin
      if (clk_en_i) begin
        parity_lvl_q <= parity_lvl;
        serr_n_lvl_q <= serr_n_lvl;
      end
      serr_out_q <= serr_out_d;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = '0;
    unique case (reg_addr_i)
      OFS_PF_BOTTOM_HI: rd_mux = pf_bottom_hi_q;
      OFS_PF_TOP_HI: rd_mux = pf_top_hi_q;
      OFS_IO_HI: rd_mux = {io_top_hi_q, io_bottom_hi_q};
      OFS_CAP_PTR: rd_mux = {24'h00_0000, CAP_PTR_VALUE};
      OFS_INTR_CTRL: begin
        rd_mux[7:0] = intr_route_q;
        rd_mux[INTR_PIN_LSB +: 8] = INTR_PIN_VALUE;
        rd_mux[CTRL_PARITY_BIT] = parity_en_q;
        rd_mux[CTRL_SERR_FWD_BIT] = serr_fwd_en_q;
        rd_mux[CTRL_ISA_BIT] = isa_en_q;
      end
      OFS_EVENT_STATUS: rd_mux[EV_W-1:0] = ev_status_q;
      OFS_EVENT_MASK: rd_mux[EV_W-1:0] = ev_mask_q;
      default: rd_mux = '0;
    endcase
  end

  // register writes; status clears by writing one, a new event wins
  always_comb begin
    pf_bottom_hi_d = pf_bottom_hi_q;
    pf_top_hi_d = pf_top_hi_q;
    io_bottom_hi_d = io_bottom_hi_q;
    io_top_hi_d = io_top_hi_q;
    intr_route_d = intr_route_q;
    parity_en_d = parity_en_q;
    serr_fwd_en_d = serr_fwd_en_q;
    isa_en_d = isa_en_q;
    ev_mask_d = ev_mask_q;
    ev_status_d = ev_status_q;
    rdata_d = rdata_q;
    irq_d = irq_q;
    if (clk_en_i) begin
      rdata_d = reg_rd_i ? rd_mux : 32'h0000_0000;
      if (reg_wr_i) begin
        unique case (reg_addr_i)
          OFS_PF_BOTTOM_HI: pf_bottom_hi_d = reg_wdata_i;
          OFS_PF_TOP_HI: pf_top_hi_d = reg_wdata_i;
          OFS_IO_HI: begin
            io_bottom_hi_d = reg_wdata_i[15:0];
            io_top_hi_d = reg_wdata_i[IO_TOP_LSB +: 16];
          end
          OFS_INTR_CTRL: begin
            // routing byte drives nothing
            intr_route_d = reg_wdata_i[7:0];
            parity_en_d = reg_wdata_i[CTRL_PARITY_BIT];
            serr_fwd_en_d = reg_wdata_i[CTRL_SERR_FWD_BIT];
            isa_en_d = reg_wdata_i[CTRL_ISA_BIT];
          end
          OFS_EVENT_STATUS: ev_status_d = ev_status_q & ~reg_wdata_i[EV_W-1:0];
          OFS_EVENT_MASK: ev_mask_d = reg_wdata_i[EV_W-1:0];
          default: ev_mask_d = ev_mask_q;
        endcase
      end
      ev_status_d = ev_status_d | ev_set;
      irq_d = |(ev_status_d & ev_mask_d);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pf_bottom_hi_q <= HI_RESET;
      pf_top_hi_q <= HI_RESET;
      io_bottom_hi_q <= IO_HI_RESET;
      io_top_hi_q <= IO_HI_RESET;
      intr_route_q <= INTR_ROUTE_RESET;
      parity_en_q <= 1'b0;
      serr_fwd_en_q <= 1'b0;
      isa_en_q <= 1'b0;
      ev_status_q <= EV_RESET;
      ev_mask_q <= EV_RESET;
      rdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end else begin
      pf_bottom_hi_q <= pf_bottom_hi_d;
      pf_top_hi_q <= pf_top_hi_d;
      io_bottom_hi_q <= io_bottom_hi_d;
      io_top_hi_q <= io_top_hi_d;
      intr_route_q <= intr_route_d;
      parity_en_q <= parity_en_d;
      serr_fwd_en_q <= serr_fwd_en_d;
      isa_en_q <= isa_en_d;
      ev_status_q <= ev_status_d;
      ev_mask_q <= ev_mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign mem_valid_o = mem_valid_q;
  assign mem_fwd_o = mem_fwd_q;
  assign io_valid_o = io_valid_q;
  assign io_fwd_o = io_fwd_q;
  assign pri_serr_fwd_o = serr_out_q;
  assign irq_o = irq_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_pf_bottom_write: assert property (
    clk_en_i && reg_wr_i && reg_addr_i == OFS_PF_BOTTOM_HI
    ##1 clk_en_i && reg_rd_i && reg_addr_i == OFS_PF_BOTTOM_HI
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("prefetch bottom high did not read back");

  a_io_top_write: assert property (
    clk_en_i && reg_wr_i && reg_addr_i == OFS_IO_HI
    |=> io_top_hi_q == $past(reg_wdata_i[31:16]))
    else $error("io top high not stored");

  a_cap_ptr_read: assert property (
    clk_en_i && reg_rd_i && reg_addr_i == OFS_CAP_PTR
    |=> reg_rdata_o == 32'h0000_0080)
    else $error("capability pointer wrong");

  a_intr_pin_zero: assert property (
    clk_en_i && reg_rd_i && reg_addr_i == OFS_INTR_CTRL
    |=> reg_rdata_o[15:8] == 8'h00)
    else $error("interrupt pin byte not zero");

  a_parity_ignored: assert property (
    !parity_en_q && !$past(ev_status_q[EV_PARITY]) |-> !ev_status_q[EV_PARITY]
    or $past(parity_en_q))
    else $error("parity event while disabled");

  a_serr_forward: assert property (
    clk_en_i && serr_fwd_en_q && !serr_n_lvl |=> pri_serr_fwd_o)
    else $error("secondary system error not forwarded");

  a_serr_blocked: assert property (
    $past(clk_en_i) && !$past(serr_fwd_en_q) |-> !pri_serr_fwd_o)
    else $error("system error forwarded while disabled");

  a_io_no_isa: assert property (
    clk_en_i && io_check_i && !io_from_secondary_i && !isa_en_q
    |=> io_valid_o && io_fwd_o == $past(io_hit))
    else $error("io forward wrong with alias blocking off");

  a_alias_blocked: assert property (
    clk_en_i && io_check_i && !io_from_secondary_i && isa_en_q && io_hit
    && io_addr_i[31:16] == 16'h0000 && io_addr_i[9:8] != 2'h0
    |=> !io_fwd_o ##0 ev_status_q[EV_ALIAS])
    else $error("isa alias forwarded downstream");

  a_alias_upstream: assert property (
    clk_en_i && io_check_i && io_from_secondary_i && isa_en_q
    && io_addr_i[31:16] == 16'h0000 && io_addr_i[9:8] != 2'h0
    |=> io_fwd_o)
    else $error("secondary alias not forwarded upstream");

  a_irq_level: assert property (
    $past(clk_en_i) |-> irq_o == |(ev_status_q & ev_mask_q))
    else $error("interrupt level mismatch");
endmodule

// file: tb/pci_agent_model.sv
/*
  Secondary bus agent: pulses the parity error and system error pins.
  Assumes go requests come from the bench on the same clock.
*/
`timescale 1ns/100ps
module pci_agent_model (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic parity_go_i,
  input wire logic serr_go_i,
  input wire logic [3:0] hold_i,
  output logic sec_parity_err_o,
  output logic secondary_system_error_in_n_o
);
  logic [3:0] par_cnt_q;
  logic [3:0] serr_cnt_q;
  // hold length sets a short or a long assertion of each pin
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      par_cnt_q <= 4'h0;
      serr_cnt_q <= 4'h0;
    end else begin
      if (parity_go_i) par_cnt_q <= hold_i;
      else if (par_cnt_q != 4'h0) par_cnt_q <= par_cnt_q - 4'h1;
      if (serr_go_i) serr_cnt_q <= hold_i;
      else if (serr_cnt_q != 4'h0) serr_cnt_q <= serr_cnt_q - 4'h1;
    end
  end
  assign sec_parity_err_o = (par_cnt_q != 4'h0);
  assign secondary_system_error_in_n_o = (serr_cnt_q == 4'h0);
endmodule

// file: tb/testbench.sv
/*
  Self-checking bench for the bridge window register block.
  Assumes the agent model drives the secondary error pins.
*/
`timescale 1ns/100ps
module testbench;
  import bridge_window_pkg::*;
  logic clock_i, rst_n_i, clk_en_i, reg_wr_i, reg_rd_i, mem_check_i, mem_valid_o, mem_fwd_o;
  logic io_check_i, io_from_secondary_i, io_valid_o, io_fwd_o, pri_serr_fwd_o, irq_o;
  logic par_go, serr_go, par_pin, serr_pin_n;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, io_addr_i, pf_bot_hi, pf_top_hi;
  logic [11:0] pf_bottom_low_i, pf_top_low_i;
  logic [3:0] io_bottom_low_i, io_top_low_i;
  logic [15:0] io_bot_hi, io_top_hi, seed;
  logic [63:0] mem_addr_i;
  logic isa;
  int num_errors = 0;
  int compares = 0;

  bridge_window_regs bridge_window_regs_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .pf_bottom_low_i(pf_bottom_low_i), .pf_top_low_i(pf_top_low_i),
    .io_bottom_low_i(io_bottom_low_i), .io_top_low_i(io_top_low_i),
    .mem_check_i(mem_check_i), .mem_addr_i(mem_addr_i), .mem_valid_o(mem_valid_o),
    .mem_fwd_o(mem_fwd_o), .io_check_i(io_check_i), .io_from_secondary_i(io_from_secondary_i),
    .io_addr_i(io_addr_i), .io_valid_o(io_valid_o), .io_fwd_o(io_fwd_o),
    .sec_parity_err_i(par_pin), .secondary_system_error_in_n_i(serr_pin_n),
    .pri_serr_fwd_o(pri_serr_fwd_o), .irq_o(irq_o));

  pci_agent_model pci_agent_model_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .parity_go_i(par_go), .serr_go_i(serr_go), .hold_i(4'hA),
    .sec_parity_err_o(par_pin), .secondary_system_error_in_n_o(serr_pin_n));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic exp_io(input logic [31:0] a, input logic sec);
    logic in_w, blk;
    in_w = (a >= {io_bot_hi, io_bottom_low_i, 12'h000}) && (a <= {io_top_hi, io_top_low_i, 12'hFFF});
    blk = isa && in_w && (a[31:16] == 16'h0000) && (a[9:8] != 2'h0);
    return sec ? (!in_w || blk) : (in_w && !blk);
  endfunction

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("rdata", reg_rdata_o, e);
  endtask

  task automatic pulse_pin(input logic serr);
    @(posedge clock_i);
    if (serr) serr_go <= 1'b1;
    else par_go <= 1'b1;
    @(posedge clock_i);
    serr_go <= 1'b0;
    par_go <= 1'b0;
    repeat (7) @(posedge clock_i);
    #1;
  endtask

  task automatic io_run();
    logic [31:0] corner [6];
    logic [31:0] a;
    corner = '{32'h0FFF, 32'h1000, 32'h4FFF, 32'h5000, 32'h1100, 32'h13FF};
    for (int i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      a = (i < 12) ? corner[i/2] : {17'h0, seed[14:0]};
      // follow the programmed upper half, so a high window is hit too
      a[31:16] = io_bot_hi;
      @(posedge clock_i);
      io_check_i <= 1'b1;
      io_addr_i <= a;
      io_from_secondary_i <= i[0];
      @(posedge clock_i);
      io_check_i <= 1'b0;
      #1;
      chk("io_valid", io_valid_o, 1'b1);
      chk("io_fwd", io_fwd_o, exp_io(a, i[0]));
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end

  initial begin
    logic [63:0] m, bot, top;
    seed = 16'h005D;
    {rst_n_i, reg_wr_i, reg_rd_i, mem_check_i, io_check_i, io_from_secondary_i} = '0;
    {par_go, serr_go, isa} = '0;
    clk_en_i = 1'b1;
    reg_addr_i = 8'h00;
    {reg_wdata_i, io_addr_i, mem_addr_i} = '0;
    pf_bottom_low_i = 12'h123;
    pf_top_low_i = 12'h456;
    io_bottom_low_i = 4'h1;
    io_top_low_i = 4'h4;
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(OFS_PF_BOTTOM_HI, 32'h0);
    rd(OFS_PF_TOP_HI, 32'h0);
    rd(OFS_IO_HI, 32'h0);
    rd(OFS_CAP_PTR, 32'h80);
    rd(OFS_INTR_CTRL, 32'h0);
    wr(OFS_CAP_PTR, 32'hFFFF_FFFF);
    rd(OFS_CAP_PTR, 32'h80);
    wr(OFS_INTR_CTRL, 32'hFFFF_FFFF);
    rd(OFS_INTR_CTRL, 32'h0007_00FF);
    wr(8'h50, 32'hFFFF_FFFF);
    rd(8'h50, 32'h0);
    seed = lfsr(seed);
    pf_bot_hi = {16'h0, seed};
    pf_top_hi = pf_bot_hi;
    // write then read with no idle cycle between the strobes
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= OFS_PF_BOTTOM_HI;
    reg_wdata_i <= pf_bot_hi;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("rdata", reg_rdata_o, pf_bot_hi);
    wr(OFS_PF_TOP_HI, pf_top_hi);
    rd(OFS_PF_BOTTOM_HI, pf_bot_hi);
    rd(OFS_PF_TOP_HI, pf_top_hi);
    // enable low: write and check strobe must both be ignored
    @(posedge clock_i);
    clk_en_i <= 1'b0;
    reg_wr_i <= 1'b1;
    reg_addr_i <= OFS_PF_TOP_HI;
    reg_wdata_i <= ~pf_top_hi;
    mem_check_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    mem_check_i <= 1'b0;
    #1;
    chk("mem_valid", mem_valid_o, 1'b0);
    @(posedge clock_i);
    clk_en_i <= 1'b1;
    rd(OFS_PF_TOP_HI, pf_top_hi);
    bot = {pf_bot_hi, pf_bottom_low_i, 20'h0_0000};
    top = {pf_top_hi, pf_top_low_i, 20'hF_FFFF};
    // boundaries first: off-by-one in either bound shows here
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      m = (i == 0) ? bot : (i == 1) ? bot - 64'h1 : (i == 2) ? top : (i == 3) ? top + 64'h1 :
        {pf_bot_hi, 4'h0, seed[11:0], 16'h0};
      @(posedge clock_i);
      mem_check_i <= 1'b1;
      mem_addr_i <= m;
      @(posedge clock_i);
      mem_check_i <= 1'b0;
      #1;
      chk("mem_valid", mem_valid_o, 1'b1);
      chk("mem_fwd", mem_fwd_o, (m >= bot) && (m <= top));
    end
    io_bot_hi = 16'h0000;
    io_top_hi = 16'h0000;
    wr(OFS_INTR_CTRL, 32'h0000_00FF);
    io_run();
    isa = 1'b1;
    wr(OFS_INTR_CTRL, 32'h0004_00FF);
    io_run();
    io_bot_hi = 16'h0001;
    io_top_hi = 16'h0001;
    wr(OFS_IO_HI, 32'h0001_0001);
    rd(OFS_IO_HI, 32'h0001_0001);
    io_run();
    rd(OFS_EVENT_STATUS, 32'h4);
    chk("irq", irq_o, 1'b0);
    wr(OFS_EVENT_MASK, 32'h4);
    chk("irq", irq_o, 1'b1);
    wr(OFS_EVENT_STATUS, 32'h4);
    chk("irq", irq_o, 1'b0);
    wr(OFS_INTR_CTRL, 32'h0000_00FF);
    pulse_pin(1'b1);
    chk("serr_fwd", pri_serr_fwd_o, 1'b0);
    pulse_pin(1'b0);
    repeat (8) @(posedge clock_i);
    rd(OFS_EVENT_STATUS, 32'h2);
    wr(OFS_EVENT_STATUS, 32'h7);
    wr(OFS_INTR_CTRL, 32'h0003_00FF);
    pulse_pin(1'b1);
    chk("serr_fwd", pri_serr_fwd_o, 1'b1);
    pulse_pin(1'b0);
    repeat (8) @(posedge clock_i);
    chk("serr_fwd", pri_serr_fwd_o, 1'b0);
    rd(OFS_EVENT_STATUS, 32'h3);
    chk("irq", irq_o, 1'b0);
    wr(OFS_EVENT_MASK, 32'h7);
    chk("irq", irq_o, 1'b1);
    wrap_up();
  end
endmodule
